//--- rtl/ubh_pkg.sv
// package for the uart boot handshake block: characters, field sizes, timing
// assumes a byte-wide uart receiver and transmitter outside this block
package ubh_pkg;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_NUL   = 8'h00;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_ONE   = 8'h31;
	localparam int         ACK_CMP_LEN  = 7;
	localparam int         HEX_DIGITS   = 8;
	localparam int         MODE_LEN     = 4;
	localparam int         TABLE_WORDS  = 256;
	localparam int         TABLE_BYTES  = 1024;
	localparam logic [31:0] CRC_INIT    = 32'hffff_ffff;
	localparam logic [31:0] CRC_POLY    = 32'hedb8_8320;
	localparam int         STR_MAX      = 8;
	// message selectors for the transmitter
	localparam logic [2:0] MSG_REQUEST  = 3'h0;
	localparam logic [2:0] MSG_ACCEPTED = 3'h1;
	localparam logic [2:0] MSG_PASSED   = 3'h2;
	localparam logic [2:0] MSG_FAILED   = 3'h3;
	localparam int         REQ_GAP_US   = 1000;
	localparam int         CLK_MHZ      = 40;
	localparam int         REQ_GAP_CYC  = REQ_GAP_US * CLK_MHZ;
	typedef enum logic [3:0] {
		ST_REQ     = 4'b0000,
		ST_ACK     = 4'b0001,
		ST_HDR     = 4'b0010,
		ST_MODE    = 4'b0011,
		ST_ACCEPT  = 4'b0100,
		ST_TABLE   = 4'b0101,
		ST_TCHK    = 4'b0110,
		ST_IMAGE   = 4'b0111,
		ST_ICHK    = 4'b1000,
		ST_FAIL    = 4'b1001,
		ST_JUMP    = 4'b1010,
		ST_WAITTX  = 4'b1011
	} ubh_state_type;
endpackage

//--- rtl/ubh_msg_tx.sv
// message sender: streams one fixed handshake string byte by byte
// assumes the uart transmitter takes a byte when valid and ready are both high
`timescale 1ns/10ps
module ubh_msg_tx (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       start,
	input  wire logic [2:0] msg_sel,
	input  wire logic       tx_ready,
	output logic            tx_valid,
	output logic [7:0]      tx_data,
	output logic            busy
);
	logic [2:0] sel_ff;
	logic [3:0] idx_ff;
	logic       busy_ff;
	logic [7:0] cur_char;
	logic [3:0] cur_len;
	// returns length and characters of each message; strings are null padded
	function automatic logic [7:0] msg_char(input logic [2:0] s, input logic [3:0] i);
		logic [63:0] str;
		str = 64'h0000_0000_0000_0000;
		case (s)
			ubh_pkg::MSG_REQUEST:  str = {"BOOTREQ", 8'h00};
			ubh_pkg::MSG_ACCEPTED: str = {"BEGIN", 24'h00_0000};
			ubh_pkg::MSG_PASSED:   str = {"DONE", 32'h0000_0000};
			default:               str = {"BADCRC", 16'h0000};
		endcase
		msg_char = str[63 - 8 * i -: 8];
	endfunction
	function automatic logic [3:0] msg_len(input logic [2:0] s);
		case (s)
			ubh_pkg::MSG_REQUEST:  msg_len = 4'h7;
			ubh_pkg::MSG_ACCEPTED: msg_len = 4'h5;
			ubh_pkg::MSG_PASSED:   msg_len = 4'h4;
			default:               msg_len = 4'h6;
		endcase
	endfunction
	assign cur_char = msg_char(sel_ff, idx_ff);
	assign cur_len  = msg_len(sel_ff);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sel_ff   <= 3'h0;
			idx_ff   <= 4'h0;
			busy_ff  <= 1'b0;
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
		end else if (!busy_ff) begin
			if (start) begin
				sel_ff  <= msg_sel;
				idx_ff  <= 4'h0;
				busy_ff <= 1'b1;
			end
		end else if (!tx_valid) begin
			tx_valid <= 1'b1;
			tx_data  <= cur_char;
		end else if (tx_ready) begin
			tx_valid <= 1'b0;
			if (idx_ff == cur_len - 4'h1)
				busy_ff <= 1'b0;
			idx_ff <= idx_ff + 4'h1;
		end
	end
	assign busy = busy_ff | start;
endmodule

//--- rtl/ubh_core.sv
// top of the uart boot handshake: parses the host reply, runs the crc checks
// and reports the result; assumes byte streams from an on-chip uart
`timescale 1ns/10ps
module ubh_core #(
	parameter bit          EARLY_REV   = 1'b0,
	parameter int unsigned REQ_GAP_CYC = ubh_pkg::REQ_GAP_CYC,
	parameter int unsigned MAX_IMAGE   = 65536
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        boot_start,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        tx_ready,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             img_wr_ff,
	output logic [31:0]      img_addr_ff,
	output logic [7:0]       img_data_ff,
	output logic             jump_ff,
	output logic [31:0]      jump_addr_ff
);
	if (REQ_GAP_CYC < 1 || MAX_IMAGE < 1) begin : g_bad_param
		$error("ubh_core: bad parameter");
	end
	// ****************************************************************
	// state and registers
	// ****************************************************************
	ubh_pkg::ubh_state_type st_ff, after_tx_ff;
	logic        boot_s1_ff, boot_s2_ff, active_ff;
	logic [31:0] word_ff, cksum_ff, size_ff, start_ff, cnt_ff, crc_ff, tcrc_ff, gap_ff;
	logic [1:0]  fld_ff;
	logic        mode1_ff;
	logic [31:0] table_mem [0:ubh_pkg::TABLE_WORDS-1];
	logic        msg_start;
	logic [2:0]  msg_sel;
	logic        tx_busy;
	// ****************************************************************
	// decode
	// ****************************************************************
	function automatic logic [3:0] hex_val(input logic [7:0] c);
		if (c >= "0" && c <= "9")
			hex_val = 4'(c - "0");
		else if (c >= "A" && c <= "F")
			hex_val = 4'(c - "A" + 8'd10);
		else
			hex_val = 4'(c - "a" + 8'd10);
	endfunction
	function automatic logic [7:0] ack_char(input logic [2:0] i);
		logic [63:0] s;
		s = {"    ACK", ubh_pkg::CH_NUL};
		ack_char = s[63 - 8 * i -: 8];
	endfunction
	logic [7:0]  crc_idx;
	logic [31:0] crc_next;
	logic [31:0] tbl_word;
	logic [31:0] tbl_crc_next;
	logic        ack_ok;
	logic        last_ack;
	assign crc_idx      = crc_ff[7:0] ^ rx_data;
	assign crc_next     = (crc_ff >> 8) ^ table_mem[crc_idx];
	// table integrity: crc-32 of the table bytes by the standard polynomial, bitwise
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h00_0000, d};
		for (int b = 0; b < 8; b++)
			r = r[0] ? ((r >> 1) ^ ubh_pkg::CRC_POLY) : (r >> 1);
		crc_byte = r;
	endfunction
	assign tbl_crc_next = crc_byte(tcrc_ff, rx_data);
	assign tbl_word     = {rx_data, word_ff[31:8]};
	assign ack_ok       = (rx_data == ack_char(cnt_ff[2:0]));
	// later revisions stop after seven characters, the earliest needs the null too
	assign last_ack     = EARLY_REV ? (cnt_ff == 32'(ubh_pkg::ACK_CMP_LEN))
					: (cnt_ff == 32'(ubh_pkg::ACK_CMP_LEN - 1));
	// ****************************************************************
	// boot entry and transmitter
	// ****************************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			boot_s1_ff <= 1'b0;
			boot_s2_ff <= 1'b0;
		end else begin
			boot_s1_ff <= boot_start;
			boot_s2_ff <= boot_s1_ff;
		end
	end
	ubh_msg_tx u_tx (
		.clock    (clock),
		.nrst     (nrst),
		.start    (msg_start),
		.msg_sel  (msg_sel),
		.tx_ready (tx_ready),
		.tx_valid (tx_valid),
		.tx_data  (tx_data),
		.busy     (tx_busy)
	);
	logic [2:0] msg_sel_q;
	logic       send_q;
	ubh_pkg::ubh_state_type after_q;
	logic       pend_ff;
	logic [2:0] pend_sel_ff;
	logic       nxt_start;
	logic [2:0] nxt_sel;
	// a decided message is held one cycle in pend, then started like a request
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			msg_start   <= 1'b0;
			msg_sel     <= ubh_pkg::MSG_REQUEST;
			pend_ff     <= 1'b0;
			pend_sel_ff <= ubh_pkg::MSG_REQUEST;
		end else begin
			msg_start   <= nxt_start;
			msg_sel     <= nxt_sel;
			pend_ff     <= send_q && !tx_busy && !msg_start;
			pend_sel_ff <= msg_sel_q;
		end
	end
	// ****************************************************************
	// handshake sequencer
	// ****************************************************************
	logic req_due;
	assign req_due = active_ff && !tx_busy && !msg_start && (gap_ff == 32'h0000_0000)
			&& (st_ff == ubh_pkg::ST_REQ || (st_ff == ubh_pkg::ST_ACK && cnt_ff == 32'h0));
	always_comb begin
		nxt_start = 1'b0;
		nxt_sel   = msg_sel;
		if (req_due) begin
			nxt_start = 1'b1;
			nxt_sel   = ubh_pkg::MSG_REQUEST;
		end else if (pend_ff) begin
			nxt_start = 1'b1;
			nxt_sel   = pend_sel_ff;
		end
	end
	task automatic send(input logic [2:0] m, input ubh_pkg::ubh_state_type nx);
		msg_sel_q   = m;
		send_q      = 1'b1;
		after_q     = nx;
	endtask
	always_comb begin
		msg_sel_q = ubh_pkg::MSG_REQUEST;
		send_q    = 1'b0;
		after_q   = ubh_pkg::ST_REQ;
		case (st_ff)
			ubh_pkg::ST_TCHK:
				if (tcrc_ff == cksum_tbl())
					send(ubh_pkg::MSG_PASSED, mode1_ff ? ubh_pkg::ST_ICHK : ubh_pkg::ST_IMAGE);
				else
					send(ubh_pkg::MSG_FAILED, ubh_pkg::ST_REQ);
			ubh_pkg::ST_ICHK:
				if (~crc_ff == cksum_ff)
					send(ubh_pkg::MSG_PASSED, ubh_pkg::ST_JUMP);
				else
					send(ubh_pkg::MSG_FAILED, ubh_pkg::ST_REQ);
			ubh_pkg::ST_ACCEPT:
				send(ubh_pkg::MSG_ACCEPTED, ubh_pkg::ST_TABLE);
			default:
				send_q = 1'b0;
		endcase
	end
	// table self-check: the last table word carries the table crc, so the
	// crc over the whole table including it leaves the fixed crc-32 residue
	function automatic logic [31:0] cksum_tbl();
		cksum_tbl = 32'hdebb_20e3;
	endfunction
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_ff       <= ubh_pkg::ST_REQ;
			after_tx_ff <= ubh_pkg::ST_REQ;
			active_ff   <= 1'b0;
			word_ff     <= 32'h0000_0000;
			cksum_ff    <= 32'h0000_0000;
			size_ff     <= 32'h0000_0000;
			start_ff    <= 32'h0000_0000;
			cnt_ff      <= 32'h0000_0000;
			crc_ff      <= ubh_pkg::CRC_INIT;
			tcrc_ff     <= ubh_pkg::CRC_INIT;
			gap_ff      <= 32'h0000_0000;
			fld_ff      <= 2'h0;
			mode1_ff    <= 1'b0;
			img_wr_ff   <= 1'b0;
			img_addr_ff <= 32'h0000_0000;
			img_data_ff <= 8'h00;
			jump_ff     <= 1'b0;
			jump_addr_ff <= 32'h0000_0000;
		end else begin
			img_wr_ff <= 1'b0;
			if (boot_s2_ff)
				active_ff <= 1'b1;
			if (req_due)
				gap_ff <= REQ_GAP_CYC;
			else if (gap_ff != 32'h0000_0000)
				gap_ff <= gap_ff - 32'h0000_0001;
			if (send_q && !tx_busy && !msg_start) begin
				after_tx_ff <= after_q;
				st_ff       <= ubh_pkg::ST_WAITTX;
			end
			case (st_ff)
				ubh_pkg::ST_REQ: if (active_ff) begin
					st_ff  <= ubh_pkg::ST_ACK;
					cnt_ff <= 32'h0000_0000;
					fld_ff <= 2'h0;
				end
				ubh_pkg::ST_ACK: if (rx_valid) begin
					if (!ack_ok)
						cnt_ff <= 32'h0000_0000;
					else if (last_ack) begin
						st_ff  <= ubh_pkg::ST_HDR;
						cnt_ff <= 32'h0000_0000;
					end else
						cnt_ff <= cnt_ff + 32'h0000_0001;
				end
				ubh_pkg::ST_HDR: if (rx_valid) begin
					word_ff <= {word_ff[27:0], hex_val(rx_data)};
					if (cnt_ff == 32'(ubh_pkg::HEX_DIGITS - 1)) begin
						cnt_ff <= 32'h0000_0000;
						fld_ff <= fld_ff + 2'h1;
						case (fld_ff)
							2'h0: cksum_ff <= {word_ff[27:0], hex_val(rx_data)};
							2'h1: size_ff  <= {word_ff[27:0], hex_val(rx_data)};
							default: begin
								start_ff <= {word_ff[27:0], hex_val(rx_data)};
								st_ff    <= ubh_pkg::ST_MODE;
								mode1_ff <= 1'b0;
							end
						endcase
					end else
						cnt_ff <= cnt_ff + 32'h0000_0001;
				end
				ubh_pkg::ST_MODE: if (rx_valid) begin
					cnt_ff <= cnt_ff + 32'h0000_0001;
					if (cnt_ff == 32'(ubh_pkg::MODE_LEN - 1)) begin
						cnt_ff   <= 32'h0000_0000;
						crc_ff   <= ubh_pkg::CRC_INIT;
						tcrc_ff  <= ubh_pkg::CRC_INIT;
						mode1_ff <= (rx_data == ubh_pkg::CH_ONE);
						if (mode1_ff || size_ff > MAX_IMAGE)
							st_ff <= ubh_pkg::ST_REQ;
						else if (rx_data == ubh_pkg::CH_ONE)
							st_ff <= ubh_pkg::ST_TABLE;
						else if (rx_data == ubh_pkg::CH_ZERO)
							st_ff <= ubh_pkg::ST_ACCEPT;
						else
							st_ff <= ubh_pkg::ST_REQ;
					end else if (rx_data != ubh_pkg::CH_ZERO)
						mode1_ff <= 1'b1;
				end
				ubh_pkg::ST_TABLE: if (rx_valid) begin
					word_ff <= tbl_word;
					tcrc_ff <= tbl_crc_next;
					cnt_ff <= cnt_ff + 32'h0000_0001;
					if (cnt_ff == 32'(ubh_pkg::TABLE_BYTES - 1)) begin
						cnt_ff <= 32'h0000_0000;
						st_ff  <= mode1_ff ? ubh_pkg::ST_IMAGE : ubh_pkg::ST_TCHK;
					end
				end
				ubh_pkg::ST_IMAGE: if (rx_valid) begin
					crc_ff      <= crc_next;
					img_wr_ff   <= 1'b1;
					img_addr_ff <= start_ff + cnt_ff;
					img_data_ff <= rx_data;
					cnt_ff      <= cnt_ff + 32'h0000_0001;
					if (cnt_ff == size_ff - 32'h0000_0001 || size_ff == 32'h0)
						st_ff <= mode1_ff ? ubh_pkg::ST_TCHK : ubh_pkg::ST_ICHK;
				end
				ubh_pkg::ST_WAITTX:
					if (!tx_busy && !msg_start && !pend_ff)
						st_ff <= after_tx_ff;
				ubh_pkg::ST_JUMP: begin
					jump_ff      <= 1'b1;
					jump_addr_ff <= start_ff;
				end
				default: ;
			endcase
		end
	end
	// no reset: the table is always rewritten before an image byte reads it
	always_ff @(posedge clock) begin
		if (st_ff == ubh_pkg::ST_TABLE && rx_valid && cnt_ff[1:0] == 2'h3)
			table_mem[cnt_ff[9:2]] <= tbl_word;
	end
endmodule

//--- tb/ubh_core_assertions.sv
// checker for ubh_core: port timing of transmit, image writes and jump
// assumes one clock domain; bound to every ubh_core by the bind below
`timescale 1ns/10ps
module ubh_core_assertions (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        boot_start,
	input wire logic        rx_valid,
	input wire logic        tx_ready,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        img_wr_ff,
	input wire logic        jump_ff,
	input wire logic [31:0] jump_addr_ff
);
	// ****
	// properties
	// ****
	logic seen_wr_ff;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			seen_wr_ff <= 1'b0;
		end else if (img_wr_ff) begin
			seen_wr_ff <= 1'b1;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte dropped or changed before acceptance");
	AST_TX_CHARSET: assert property (tx_valid |-> tx_data inside {8'h41, 8'h42, 8'h43,
		8'h44, 8'h45, 8'h47, 8'h49, 8'h4e, 8'h4f, 8'h51, 8'h52, 8'h54})
		else $error("tx byte outside the handshake strings");
	AST_IDLE_QUIET: assert property (!boot_start [*3] |-> !tx_valid && !img_wr_ff)
		else $error("activity without serial boot entry");
	AST_RESET_QUIET: assert property ($rose(nrst) |-> !tx_valid && !img_wr_ff && !jump_ff)
		else $error("outputs active right after reset");
	AST_JUMP_STANDS: assert property (jump_ff |=> jump_ff && $stable(jump_addr_ff))
		else $error("jump dropped or address moved");
	AST_JUMP_AFTER_IMAGE: assert property ($rose(jump_ff) |-> seen_wr_ff)
		else $error("jump without any image byte");
	AST_NO_WR_AFTER_JUMP: assert property (jump_ff |-> !img_wr_ff)
		else $error("image write after jump");
	AST_WR_FROM_RX: assert property (img_wr_ff |-> $past(rx_valid) || $past(rx_valid, 2)
		|| $past(rx_valid, 3))
		else $error("image write with no received byte");
endmodule
bind ubh_core ubh_core_assertions chk_u (.clock(clock), .nrst(nrst), .boot_start(boot_start),
	.rx_valid(rx_valid), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
	.img_wr_ff(img_wr_ff), .jump_ff(jump_ff), .jump_addr_ff(jump_addr_ff));

//--- tb/ubh_host_model.sv
// host at the far end of the uart: sends bytes, collects and paces device replies
// assumes byte-level uart ports; slow makes tx_ready high one cycle in four
`timescale 1ns/10ps
module ubh_host_model (
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_data
);
	// ****
	// byte traffic
	// ****
	logic [7:0]  got_q[$];
	logic [31:0] cyc = 32'h0000_0000;
	int          slow = 0;
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	always @(posedge clock) begin
		if (nrst === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) got_q.push_back(tx_data);
		cyc++;
		tx_ready <= #1 (slow == 0) || (cyc[1:0] == 2'b11);
	end
	// idle data shows the inverse so a stale byte is never mistaken for a fresh one
	task automatic put(input logic [7:0] b);
		@(posedge clock);
		#1 rx_valid = 1'b1;
		rx_data = b;
		@(posedge clock);
		#1 rx_valid = 1'b0;
		rx_data = ~b;
		repeat (2) @(posedge clock);
	endtask
endmodule

//--- tb/tb.sv
// bench for ubh_core: runs boot sessions through the host model against a crc model
// assumes ubh_host_model and the bound checker; request gap shortened to 50
`timescale 1ns/10ps
module tb;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic        boot_start = 1'b0;
	logic        rx_valid, tx_ready, tx_valid, img_wr_ff, jump_ff;
	logic [7:0]  rx_data, tx_data, img_data_ff;
	logic [31:0] img_addr_ff, jump_addr_ff, tbl[256];
	logic [31:0] seed = 32'h0000_c2d0;
	logic [39:0] exp_q[$];
	int          errors = 0;
	int          cmp_count = 0;
	always #12.5 clock = ~clock;
	ubh_host_model host_u (.clock(clock), .nrst(nrst), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
	ubh_core #(.REQ_GAP_CYC(50)) dut_u (.clock(clock), .nrst(nrst), .boot_start(boot_start),
		.rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .img_wr_ff(img_wr_ff), .img_addr_ff(img_addr_ff),
		.img_data_ff(img_data_ff), .jump_ff(jump_ff), .jump_addr_ff(jump_addr_ff));
	// ****
	// helpers
	// ****
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
		return tbl[c[7:0] ^ b] ^ (c >> 8);
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic put_hex(input logic [31:0] v);
		logic [3:0] d;
		for (int k = 7; k >= 0; k--) begin
			d = v[4*k+:4];
			host_u.put(d < 4'ha ? ubh_pkg::CH_ZERO + 8'(d) : 8'h37 + 8'(d));
		end
	endtask
	// skips whatever precedes the wanted string, so pending requests do not matter
	task automatic wait_msg(input string s);
		logic [7:0] t[$];
		logic       hit;
		hit = 1'b0;
		for (int n = 0; n < 6000 && !hit; n++) begin
			@(posedge clock);
			while (host_u.got_q.size() > 0 && !hit) begin
				t.push_back(host_u.got_q.pop_front());
				if (t.size() > s.len()) void'(t.pop_front());
				hit = (t.size() == s.len());
				foreach (t[k]) if (t[k] !== s[k]) hit = 1'b0;
			end
		end
		check(hit, 1'b1);
	endtask
	task automatic restart(input int slow);
		#1 nrst = 1'b0;
		boot_start = 1'b0;
		host_u.slow = slow;
		repeat (12) @(posedge clock);
		host_u.got_q.delete();
		exp_q.delete();
		#1 nrst = 1'b1;
		repeat (4) @(posedge clock);
		check(host_u.got_q.size(), 0);
		#1 boot_start = 1'b1;
		wait_msg("BOOTREQ");
		wait_msg("BOOTREQ");
	endtask
	task automatic boot(input logic m1, input logic bad_t, input logic bad_i);
		logic [31:0] c, addr, len;
		logic [7:0]  img[$];
		c = ubh_pkg::CRC_INIT;
		addr = xs();
		len = 32'd12 + (xs() % 32'd8);
		repeat (len) img.push_back(8'(xs()));
		foreach (img[i]) c = crc_step(c, img[i]);
		repeat (4) host_u.put(ubh_pkg::CH_SPACE);
		host_u.put(8'h41);
		host_u.put(8'h43);
		host_u.put(8'h4b);
		put_hex(~c ^ 32'(bad_i));
		put_hex(len);
		put_hex(addr);
		repeat (3) host_u.put(ubh_pkg::CH_ZERO);
		host_u.put(m1 ? ubh_pkg::CH_ONE : ubh_pkg::CH_ZERO);
		if (!m1) wait_msg("BEGIN");
		for (int j = 0; j < 1024; j++) host_u.put(tbl[j/4][8*(j%4)+:8] ^ 8'(bad_t && j == 5));
		if (bad_t) begin
			wait_msg("BADCRC");
			wait_msg("BOOTREQ");
			return;
		end
		if (!m1) wait_msg("DONE");
		foreach (img[i]) begin
			exp_q.push_back({addr + 32'(i), img[i]});
			host_u.put(img[i]);
		end
		if (m1) wait_msg("DONE");
		if (bad_i) begin
			wait_msg("BADCRC");
			check(jump_ff, 1'b0);
			wait_msg("BOOTREQ");
		end else begin
			wait_msg("DONE");
			for (int n = 0; n < 300 && jump_ff !== 1'b1; n++) @(posedge clock);
			check({jump_ff, jump_addr_ff}, {1'b1, addr});
			check(exp_q.size(), 0);
		end
	endtask
	always @(posedge clock) begin
		if (nrst === 1'b1 && img_wr_ff === 1'b1) begin
			check({img_addr_ff, img_data_ff}, exp_q.size() > 0 ? exp_q.pop_front() : '1);
		end
	end
	// ****
	// sequence
	// ****
	initial begin
		logic [31:0] c;
		for (int i = 0; i < 256; i++) begin
			c = 32'(i);
			repeat (8) c = c[0] ? (c >> 1) ^ ubh_pkg::CRC_POLY : c >> 1;
			tbl[i] = c;
		end
		c = ubh_pkg::CRC_INIT;
		for (int j = 0; j < 1020; j++) c = crc_step(c, tbl[j/4][8*(j%4)+:8]);
		tbl[255] = ~c;
		restart(0);
		boot(1'b0, 1'b0, 1'b0);
		restart(1);
		host_u.put(8'h5a);
		boot(1'b1, 1'b0, 1'b0);
		restart(0);
		boot(1'b0, 1'b1, 1'b0);
		boot(1'b1, 1'b0, 1'b1);
		boot(1'b0, 1'b0, 1'b0);
		tally_and_finish();
	end
	initial begin
		#2250000;
		errors++;
		tally_and_finish();
	end
endmodule
